// File: pkg/sadc_defines.vh
// Constants for the successive-approximation converter control block.
// Assumes a single 100 MHz clock and a plain strobe register port.
//
// Functional notes
// - Clock select: 00 div2, 01 div8, 10 div32, 11 internal RC oscillator.
// - With power on, writing start bit begins conversion; reads 1 meanwhile.
// - Hardware clears start bit when conversion finishes.
// - Power bit 1 runs converter; 0 shuts it off.
// - Eight-bit result produced by successive approximation of held sample.
// - Reference selectable: supply or input three reference pin.
// - Pin config field maps analog/digital pins and reference per table.
// - Pin config bits 7-3 and control bit 1 read zero.
// - Implemented control bits read/write, reset to zero.
// - Sleep conversion only with RC oscillator clock selected.
// - Completion raises the converter done flag for interrupt use.
// - At least two bit periods before next acquisition after conversion.
// - Small variant has five inputs, large variant eight.
// - Each conversion lasts nine and a half bit periods.
// - Clearing start aborts without result update, then waits two periods.
// - Completion loads result; in sleep wakes if enabled, else powers down.
// - Special event trigger sets start bit only when power bit set.
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH
`define SADC_ADDR_CONV 8'h1f
`define SADC_ADDR_PCFG 8'h9f
`define SADC_ADDR_RESULT 8'h1e
`define SADC_ADDR_FLAGS 8'h0c
`define SADC_CLK_DIV2 2'h0
`define SADC_CLK_DIV8 2'h1
`define SADC_CLK_DIV32 2'h2
`define SADC_CLK_RC 2'h3
`define SADC_HALF_DIV2 6'h01
`define SADC_HALF_DIV8 6'h04
`define SADC_HALF_DIV32 6'h10
`define SADC_CONV_HALVES 5'h13
`define SADC_WAIT_HALVES 5'h04
`define SADC_CMP_HALF 5'h03
`define SADC_CCP_TRIG_MODE 4'hb
`define SADC_BIT_START 2
`define SADC_BIT_POWER 0
`define SADC_BIT_DONE 6
`define SADC_BIT_IEN 6
`endif

// File: core/sadc_ctrl.v
// Successive-approximation converter control: registers, bit clock,
// sequencer and pin map. Assumes comparator input synchronous to clock
// and an external RC oscillator tick already aligned to this clock.
//
// Added by the designer: strobed register access.
`include "sadc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl #(
   parameter NUM_INPUTS = 8,
   parameter RES_BITS = 8
) (
   input wire clock, // System clock 100 MHz
   input wire sys_rst, // Synchronous reset, active high
   input wire [7:0] reg_addr, // Register address
   input wire [7:0] reg_wdata, // Write data
   input wire reg_wr, // Write strobe
   input wire reg_rd, // Read strobe
   output reg [7:0] reg_rdata, // Read data, cycle after strobe
   input wire rc_osc_tick, // One pulse per RC oscillator half period
   input wire sleep_mode, // Device is sleeping
   input wire [3:0] ccp_mode, // Capture/compare two mode field
   input wire ccp_trigger, // Special event trigger pulse
   input wire cmp_in, // Comparator: sample at or above trial level
   output reg [RES_BITS-1:0] dac_code, // Trial code to the DAC
   output reg [2:0] mux_channel, // Selected analog input
   output reg sample_en, // Sampling switch closed
   output reg analog_on, // Analog bias enabled
   output reg ref_from_pin, // Reference taken from input three pin
   output reg [7:0] analog_pin_mask, // 1 marks an analog pin
   output reg conv_done_flag, // Completion flag, sticky
   output reg conv_done_irq, // Completion interrupt request level
   output reg wake_req // Wake pulse from sleep
);

   // ****************************************
   // Registers and states
   // ****************************************
   localparam ST_IDLE = 2'h0;
   localparam ST_CONV = 2'h1;
   localparam ST_WAIT = 2'h2;

   reg [1:0] clk_sel_r;
   reg [2:0] chan_r;
   reg start_r;
   reg power_r;
   reg [2:0] pcfg_r;
   reg ien_r;
   reg [RES_BITS-1:0] result_r;
   reg [RES_BITS-1:0] sar_r;
   reg [RES_BITS-1:0] trial_r;
   reg [1:0] state_r;
   reg [5:0] div_cnt_r;
   reg [4:0] half_cnt_r;
   reg idle_off_r;
   reg [5:0] half_div;
   reg half_tick;
   reg [7:0] mask_nxt;
   reg ref_nxt;
   wire wr_conv;
   wire start_clr_sw;
   wire conv_end;
   wire trig_start;
   wire [RES_BITS-1:0] bit_now;
   wire [3:0] bit_idx;
   wire flag_clr;

   assign wr_conv = reg_wr && (reg_addr == `SADC_ADDR_CONV);
   assign start_clr_sw = wr_conv && !reg_wdata[`SADC_BIT_START];
   // Writing zero to the done bit clears it; a one leaves it alone
   assign flag_clr = reg_wr && (reg_addr == `SADC_ADDR_FLAGS) &&
      !reg_wdata[`SADC_BIT_DONE];
   assign trig_start = power_r && ccp_trigger &&
      (ccp_mode == `SADC_CCP_TRIG_MODE);
   assign conv_end = (state_r == ST_CONV) && half_tick &&
      (half_cnt_r == `SADC_CONV_HALVES - 5'h01);
   // Bit under trial: one bit per full period after the first full period
   assign bit_idx = half_cnt_r[4:1];
   assign bit_now = (bit_idx >= 4'h1 && bit_idx <= RES_BITS) ?
      ({{(RES_BITS-1){1'b0}}, 1'b1} << (RES_BITS - bit_idx)) :
      {RES_BITS{1'b0}};

   // ****************************************
   // Bit period clock
   // ****************************************
   // clock select
   always @* begin
      case (clk_sel_r)
         `SADC_CLK_DIV2: begin
            half_div = `SADC_HALF_DIV2;
         end
         `SADC_CLK_DIV8: begin
            half_div = `SADC_HALF_DIV8;
         end
         `SADC_CLK_DIV32: begin
            half_div = `SADC_HALF_DIV32;
         end
         default: begin
            // RC source paces itself, the divider is unused
            half_div = 6'h00;
         end
      endcase
      if (clk_sel_r == `SADC_CLK_RC)
         half_tick = rc_osc_tick;
      else
         half_tick = !sleep_mode && (div_cnt_r == half_div - 6'h01);
   end

   always @(posedge clock) begin
      if (sys_rst || state_r == ST_IDLE || half_tick)
         div_cnt_r <= 6'h00;
      else
         div_cnt_r <= div_cnt_r + 6'h01;
   end

   // ****************************************
   // Conversion sequencer
   // ****************************************
   always @(posedge clock) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
         half_cnt_r <= 5'h00;
         sar_r <= {RES_BITS{1'b0}};
         trial_r <= {RES_BITS{1'b0}};
         result_r <= {RES_BITS{1'b0}};
         idle_off_r <= 1'b0;
      end else begin
         if (!power_r) begin
            state_r <= ST_IDLE;
            idle_off_r <= 1'b0;
         end
         case (state_r)
            ST_IDLE: begin
               half_cnt_r <= 5'h00;
               if (power_r && (trig_start || (wr_conv &&
                   reg_wdata[`SADC_BIT_START] && !start_r))) begin
                  state_r <= ST_CONV;
                  sar_r <= {RES_BITS{1'b0}};
                  trial_r <= {1'b1, {(RES_BITS-1){1'b0}}};
                  idle_off_r <= 1'b0;
               end
            end
            ST_CONV: begin
               if (start_clr_sw ||
                   (sleep_mode && clk_sel_r != `SADC_CLK_RC)) begin
                  state_r <= ST_WAIT;
                  half_cnt_r <= 5'h00;
                  if (sleep_mode)
                     idle_off_r <= 1'b1;
               end else if (half_tick) begin
                  half_cnt_r <= half_cnt_r + 5'h01;
                  if (half_cnt_r[0] && bit_now != {RES_BITS{1'b0}}) begin
                     if (cmp_in)
                        sar_r <= sar_r | bit_now;
                     trial_r <= (cmp_in ? (sar_r | bit_now) : sar_r) |
                        (bit_now >> 1);
                  end
                  if (conv_end) begin
                     result_r <= cmp_in ? (sar_r | bit_now) : sar_r;
                     state_r <= ST_WAIT;
                     half_cnt_r <= 5'h00;
                     // asleep without interrupt the module turns off
                     if (sleep_mode && !ien_r)
                        idle_off_r <= 1'b1;
                  end
               end
            end
            ST_WAIT: begin
               if (half_tick)
                  half_cnt_r <= half_cnt_r + 5'h01;
               if (half_tick && half_cnt_r == `SADC_WAIT_HALVES - 5'h01)
                  state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Start bit, done flag and wake
   // ****************************************
   always @(posedge clock) begin
      if (sys_rst) begin
         start_r <= 1'b0;
         conv_done_flag <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         if (conv_end) begin
            start_r <= 1'b0;
         end else if (wr_conv) begin
            // Old power bit decides, so power and start take two writes
            start_r <= power_r && reg_wdata[`SADC_BIT_START] &&
               (state_r == ST_IDLE || start_r);
         end else if (trig_start && state_r == ST_IDLE) begin
            start_r <= 1'b1;
         end
         if (conv_end) begin
            conv_done_flag <= 1'b1;
         end else if (flag_clr) begin
            conv_done_flag <= 1'b0;
         end
         // wake only where the interrupt may fire
         wake_req <= conv_end && sleep_mode && ien_r;
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   always @(posedge clock) begin
      if (sys_rst) begin
         clk_sel_r <= 2'h0;
         chan_r <= 3'h0;
         power_r <= 1'b0;
         pcfg_r <= 3'h0;
         ien_r <= 1'b0;
      end else begin
         if (wr_conv) begin
            clk_sel_r <= reg_wdata[7:6];
            chan_r <= reg_wdata[5:3];
            power_r <= reg_wdata[`SADC_BIT_POWER];
         end
         if (reg_wr && reg_addr == `SADC_ADDR_PCFG)
            pcfg_r <= reg_wdata[2:0];
         if (reg_wr && reg_addr == `SADC_ADDR_FLAGS)
            ien_r <= reg_wdata[`SADC_BIT_IEN + 1];
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `SADC_ADDR_CONV: reg_rdata <= {clk_sel_r, chan_r,
               start_r, 1'b0, power_r};
            `SADC_ADDR_PCFG: reg_rdata <= {5'h00, pcfg_r};
            `SADC_ADDR_RESULT: reg_rdata <= result_r;
            `SADC_ADDR_FLAGS: reg_rdata <= {ien_r, conv_done_flag,
               6'h00};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         // Data stand one cycle only, then the port idles at zero
         reg_rdata <= 8'h00;
      end
   end

   // ****************************************
   // Pin map and analog controls
   // ****************************************
   // pin config table
   always @* begin
      case (pcfg_r)
         3'h0: begin
            mask_nxt = 8'hff;
            ref_nxt = 1'b0;
         end
         3'h1: begin
            mask_nxt = 8'hf7;
            ref_nxt = 1'b1;
         end
         3'h2: begin
            mask_nxt = 8'h1f;
            ref_nxt = 1'b0;
         end
         3'h3: begin
            mask_nxt = 8'h17;
            ref_nxt = 1'b1;
         end
         3'h4: begin
            mask_nxt = 8'h0b;
            ref_nxt = 1'b0;
         end
         // Code five repeats code one
         3'h5: begin
            mask_nxt = 8'hf7;
            ref_nxt = 1'b1;
         end
         // All digital, supply reference
         3'h6, 3'h7: begin
            mask_nxt = 8'h00;
            ref_nxt = 1'b0;
         end
         default: begin
            mask_nxt = 8'h00;
            ref_nxt = 1'b0;
         end
      endcase
      if (NUM_INPUTS < 8)
         mask_nxt = mask_nxt & ((8'h01 << NUM_INPUTS) - 8'h01);
   end

   always @(posedge clock) begin
      if (sys_rst) begin
         analog_pin_mask <= 8'h00;
         ref_from_pin <= 1'b0;
      end else begin
         analog_pin_mask <= mask_nxt;
         ref_from_pin <= ref_nxt;
      end
   end

   // ****************************************
   // Analog controls
   // ****************************************
   always @(posedge clock) begin
      if (sys_rst) begin
         mux_channel <= 3'h0;
         dac_code <= {RES_BITS{1'b0}};
         sample_en <= 1'b0;
         analog_on <= 1'b0;
         conv_done_irq <= 1'b0;
      end else begin
         mux_channel <= chan_r;
         dac_code <= trial_r;
         // Sampling continues whenever idle with the bias on, so acquisition starts itself
         sample_en <= power_r && !idle_off_r && state_r == ST_IDLE;
         // off after a sleep abort or a sleep completion without interrupt, power bit kept
         analog_on <= power_r && !idle_off_r;
         conv_done_irq <= conv_done_flag && ien_r;
      end
   end

endmodule
`default_nettype wire

// File: test/sadc_partner.sv
// Held sample and comparator beside the converter control block.
// Assumes the bench sets the analog level before sampling starts.
`timescale 1ns/1ps
`default_nettype none
module sadc_partner (
   input wire logic clock, // System clock
   input wire logic sample_en, // Sampling switch closed
   input wire logic [7:0] level, // Level at the selected input
   input wire logic [7:0] dac_code, // Trial code
   output logic cmp_in // Held sample at or above trial
);
   logic [7:0] held_r;
   always @(posedge clock) if (sample_en) held_r <= level;
   assign cmp_in = held_r >= dac_code;
endmodule
`default_nettype wire

// File: test/sadc_ctrl_monitor.sv
// Port checker for the converter control block.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl_monitor (
   input wire logic clock, // Clock
   input wire logic sys_rst, // Reset
   input wire logic [7:0] reg_addr, // Address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic [7:0] analog_pin_mask, // Analog pins
   input wire logic ref_from_pin, // Pin reference
   input wire logic sample_en, // Sampling
   input wire logic analog_on, // Bias on
   input wire logic conv_done_flag, // Done flag
   input wire logic conv_done_irq, // Interrupt level
   input wire logic wake_req // Wake pulse
);
   // ****
   // Checks
   // ****
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_rd_pcfg; reg_rd && reg_addr == 8'h9f; endsequence
   sequence s_rd_conv; reg_rd && reg_addr == 8'h1f; endsequence
   sequence s_wr_dig;
      reg_wr && reg_addr == 8'h9f && reg_wdata[2:1] == 2'h3;
   endsequence
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not idle");
   chk_pcfg_zero: assert property (s_rd_pcfg |=> reg_rdata[7:3] == 5'h00)
      else $error("pin config high bits set");
   chk_conv_bit: assert property (s_rd_conv |=> !reg_rdata[1])
      else $error("control bit one set");
   chk_all_digital: assert property (s_wr_dig |-> ##2 analog_pin_mask == 0)
      else $error("analog pin left");
   chk_ref_pin: assert property (ref_from_pin |-> !analog_pin_mask[3])
      else $error("reference pin marked analog");
   chk_sample_power: assert property (sample_en |-> analog_on)
      else $error("sampling while off");
   chk_irq_flag: assert property (conv_done_irq |-> $past(conv_done_flag))
      else $error("irq without flag");
   chk_wake_pulse: assert property (wake_req |=> !wake_req)
      else $error("wake not a pulse");
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the converter control block.
// Assumes the partner model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, sleep_mode = 0;
   logic rc_osc_tick = 0, ccp_trigger = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, rdv, level = 0, d, ien;
   logic [3:0] ccp_mode = 0;
   wire logic [7:0] reg_rdata, dac_code, analog_pin_mask;
   wire logic [2:0] mux_channel;
   wire logic cmp_in, sample_en, analog_on, ref_from_pin;
   wire logic conv_done_flag, conv_done_irq, wake_req;
   int n_errors = 0, tests_run = 0, seed = 75266, cnt, tk = 0, i;
   int hv[4] = '{1, 4, 16, 5};
   logic [7:0] pmap[8] = '{8'hff, 8'hf7, 8'h1f, 8'h17, 8'h0b, 8'hf7, 0, 0};
   logic [7:0] res_m = 0;
   sadc_ctrl i_dut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .rc_osc_tick, .sleep_mode, .ccp_mode,
      .ccp_trigger, .cmp_in, .dac_code, .mux_channel, .sample_en,
      .analog_on, .ref_from_pin, .analog_pin_mask, .conv_done_flag,
      .conv_done_irq, .wake_req);
   sadc_partner i_far (.clock, .sample_en, .level, .dac_code, .cmp_in);
   always #5 clock = ~clock;
   // RC tick every five clocks
   always @(posedge clock) begin
      tk <= (tk == 4) ? 0 : tk + 1;
      rc_osc_tick <= (tk == 4);
   end
   // ****
   // Bus tasks
   // ****
   task automatic chk(input logic [7:0] seen, exp, input string nm);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rdv = reg_rdata;
   endtask
   task automatic conv(input logic [1:0] cs, input logic [2:0] ch);
      level <= $random(seed);
      wr(8'h1f, {cs, ch, 3'h1});
      rd(8'h1f);
      chk(rdv, {cs, ch, 3'h1}, "conv cfg");
      wr(8'h0c, ien);
      repeat (40) @(posedge clock);
      wr(8'h1f, {cs, ch, 3'h5});
      cnt = 0;
      do begin
         rd(8'h1f);
         cnt += 2;
      end while (rdv[2] === 1'b1 && cnt < 3000);
      res_m = level;
      chk(cnt >= 19 * hv[cs] && cnt <= 19 * hv[cs] + 12, 1, "time");
      chk(mux_channel, ch, "channel");
      rd(8'h1e);
      chk(rdv, res_m, "result");
      rd(8'h0c);
      chk(rdv[6], 1, "done flag");
      chk(conv_done_irq, ien[7], "irq");
      wr(8'h0c, ien);
      repeat (100) @(posedge clock);
   endtask
   task automatic trig;
      @(posedge clock);
      ccp_trigger <= 1'b1;
      @(posedge clock);
      ccp_trigger <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   initial begin
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      rd(8'h1f);
      chk(rdv, 0, "conv reset");
      rd(8'h9f);
      chk(rdv, 0, "pcfg reset");
      rd(8'h55);
      chk(rdv, 0, "unmapped");
      for (i = 0; i < 8; i++) begin
         d = $random(seed);
         d[2:0] = i;
         wr(8'h9f, d);
         rd(8'h9f);
         chk(rdv, i, "pcfg");
         chk(analog_pin_mask, pmap[i], "mask");
         chk(ref_from_pin, i == 1 || i == 3 || i == 5, "ref");
         d = $random(seed);
         d[0] = 1'b0;
         wr(8'h1f, d);
         rd(8'h1f);
         chk(rdv, d & 8'hf9, "conv off");
      end
      wr(8'h9f, 0);
      for (i = 0; i < 4; i++) begin
         ien = i[0] ? 8'h80 : 8'h00;
         conv(i, $random(seed));
      end
      level <= ~level;
      wr(8'h1f, 8'h01);
      repeat (40) @(posedge clock);
      wr(8'h1f, 8'h05);
      repeat (6) @(posedge clock);
      wr(8'h1f, 8'h01);
      repeat (20) @(posedge clock);
      rd(8'h1e);
      chk(rdv, res_m, "abort keeps");
      ccp_mode <= 4'hb;
      trig();
      rd(8'h1f);
      chk(rdv[2], 1, "trigger on");
      repeat (60) @(posedge clock);
      wr(8'h1f, 8'h00);
      rd(8'h1f);
      chk(rdv[0], 0, "power bit");
      chk(analog_on, 0, "power off");
      trig();
      rd(8'h1f);
      chk(rdv[2], 0, "trigger off");
      wr(8'h1f, 8'h01);
      repeat (40) @(posedge clock);
      wr(8'h1f, 8'h05);
      sleep_mode <= 1'b1;
      repeat (8) @(posedge clock);
      chk(analog_on, 0, "sleep abort");
      tally_and_finish();
   end
   initial begin
      #300us;
      n_errors++;
      tally_and_finish();
   end
endmodule
bind sadc_ctrl sadc_ctrl_monitor i_mon (.clock, .sys_rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .analog_pin_mask,
   .ref_from_pin, .sample_en, .analog_on, .conv_done_flag,
   .conv_done_irq, .wake_req);
`default_nettype wire
